//--- dv/dmac_mem_model.sv
`default_nettype none
module dmac_mem_model (
    input  wire logic        core_clk_i,
    input  wire logic [15:0] prog_addr_i,
    input  wire logic        prog_rd_i,
    output logic [15:0]      prog_rdata_o,
    input  wire logic [15:0] data_addr_i,
    input  wire logic        data_rd_i,
    output logic [15:0]      data_rdata_o,
    input  wire logic        data_wr_i,
    input  wire logic [15:0] data_waddr_i,
    input  wire logic [15:0] data_wdata_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] pmem [0:65535];
    logic [15:0] dmem [0:65535];
    // flat spaces: on-chip and off-chip places answer alike
    initial begin
        for (int i = 0; i < 65536; i++) begin
            pmem[i] = 16'(i * 40503 + 7);
            dmem[i] = 16'(i * 12347 + 91);
        end
    end
    // unread ports show the inverse so a stale word never matches
    assign prog_rdata_o = prog_rd_i ? pmem[prog_addr_i] : ~pmem[prog_addr_i];
    assign data_rdata_o = data_rd_i ? dmem[data_addr_i] : ~dmem[data_addr_i];
    always @(posedge core_clk_i) begin
        if (data_wr_i) begin
            dmem[data_waddr_i] <= data_wdata_i;
        end
    end
endmodule
`default_nettype wire

//--- dv/dmac_tb_top.sv
`default_nettype none
module dmac_tb_top
    import dmac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic        start_i = 1'b0;
    dmac_req_t   req_i = '0;
    logic [1:0]  reg_addr_i = '0;
    logic [15:0] reg_wdata_i = '0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic        busy_o, prog_rd_o, data_rd_o, data_wr_o;
    logic [15:0] prog_addr_o, prog_rdata_i, data_addr_o, data_rdata_i;
    logic [15:0] data_waddr_o, data_wdata_o, multiplicand_o, reg_rdata_o;
    logic [31:0] product_o;
    int          err_count = 0;
    int          cmp_count = 0;
    logic [31:0] acc = '0;
    logic [31:0] prod = '0;
    logic [15:0] mcand = '0;
    logic        cy = 1'b0;
    logic        ovf = 1'b0;
    dmac_ctrl_t  ctrl;
    logic [15:0] exp_mv [logic [15:0]];

    always #50 core_clk_i = ~core_clk_i;

    dmac_core dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .start_i(start_i), .req_i(req_i), .busy_o(busy_o),
        .prog_addr_o(prog_addr_o), .prog_rd_o(prog_rd_o),
        .prog_rdata_i(prog_rdata_i), .data_addr_o(data_addr_o),
        .data_rd_o(data_rd_o), .data_rdata_i(data_rdata_i),
        .data_wr_o(data_wr_o), .data_waddr_o(data_waddr_o),
        .data_wdata_o(data_wdata_o), .product_o(product_o),
        .multiplicand_o(multiplicand_o), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
    dmac_mem_model mem (.core_clk_i(core_clk_i), .prog_addr_i(prog_addr_o),
        .prog_rd_i(prog_rd_o), .prog_rdata_o(prog_rdata_i),
        .data_addr_i(data_addr_o), .data_rd_i(data_rd_o),
        .data_rdata_o(data_rdata_i), .data_wr_i(data_wr_o),
        .data_waddr_i(data_waddr_o), .data_wdata_i(data_wdata_o));

    task automatic summarize;
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rw(input logic [1:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rr(input logic [1:0] a, output logic [15:0] d);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask

    function automatic logic in_blk(input logic [15:0] a);
        return (a >= DMAC_BLK2_LO && a <= DMAC_BLK2_HI) ||
            (!ctrl.block_zero_config_bit && a >= DMAC_BLK0_LO
             && a <= DMAC_BLK0_HI)
            || (a >= DMAC_BLK1_LO && a <= DMAC_BLK1_HI) ||
            (ctrl.expanded_ram && a >= DMAC_BLK3_LO && a <= DMAC_BLK3_HI);
    endfunction

    task automatic acc_step(input logic sub);
        logic [32:0] r;
        logic [31:0] s;
        case (ctrl.product_shift_mode)
            2'h1: s = prod << 1;
            2'h2: s = prod << 4;
            2'h3: s = 32'($signed(prod) >>> 6);
            default: s = prod;
        endcase
        r = sub ? {1'b0, acc} - {1'b0, s} : {1'b0, acc} + {1'b0, s};
        cy = sub ? !r[32] : r[32];
        if ((acc[31] ^ s[31] ^ sub) == 1'b0 && r[31] != acc[31]) begin
            ovf = 1'b1;
            if (ctrl.overflow_saturate_mode) begin
                r[31:0] = acc[31] ? DMAC_SAT_NEG : DMAC_SAT_POS;
            end
        end
        acc = r[31:0];
    endtask

    task automatic chk_state;
        logic [15:0] v;
        rr(DMAC_REG_ACC_LO, v);
        chk("acc_lo", 32'(v), 32'(acc[15:0]));
        rr(DMAC_REG_ACC_HI, v);
        chk("acc_hi", 32'(v), 32'(acc[31:16]));
        rr(DMAC_REG_STATUS, v);
        chk("status", 32'(v), {30'h0, ovf, cy});
        chk("product", product_o, prod);
        chk("multiplicand", 32'(multiplicand_o), 32'(mcand));
    endtask

    task automatic run(input dmac_req_t q);
        int n, wc, ew;
        logic [15:0] da, pw, dw, pa;
        n = (q.op == DMAC_OP_LOAD_SUB) ? 1 : int'(q.repeat_count) + 1;
        da = q.dma;
        wc = 0;
        ew = 0;
        start_i <= 1'b1;
        req_i <= q;
        @(posedge core_clk_i);
        start_i <= 1'b0;
        for (int i = 0; i <= n; i++) begin
            #1;
            wc += int'(data_wr_o === 1'b1);
            if (i < n) begin
                chk("busy", 32'(busy_o), 32'h1);
                chk("data_addr", 32'(data_addr_o), 32'(da));
                dw = mem.dmem[da];
                if (q.op == DMAC_OP_LOAD_SUB) begin
                    acc_step(1'b1);
                end else begin
                    pa = q.pma + 16'(i);
                    chk("prog_addr", 32'(prog_addr_o), 32'(pa));
                    pw = mem.pmem[pa];
                    acc_step(1'b0);
                    prod = 32'(int'($signed(dw)) * int'($signed(pw)));
                    if (q.op == DMAC_OP_TABLE_MOVE && in_blk(da)) begin
                        ew++;
                        exp_mv[da + 16'h1] = dw;
                    end
                end
                mcand = dw;
                if (!q.direct && q.ptr_step != DMAC_PTR_KEEP) begin
                    da = (q.ptr_step == DMAC_PTR_INC) ? da + 16'h1
                                                      : da - 16'h1;
                end
            end else begin
                chk("busy_end", 32'(busy_o), 32'h0);
                chk("prefetch_restore", 32'(prog_addr_o), 32'h0);
            end
            // a start while busy must be ignored
            start_i <= (i == 0 && n > 2);
            @(posedge core_clk_i);
        end
        #1;
        chk("moves", 32'(wc), 32'(ew));
        foreach (exp_mv[a]) begin
            chk("moved_word", 32'(mem.dmem[a]), 32'(exp_mv[a]));
        end
        exp_mv.delete();
    endtask

    initial begin
        #1_000_000;
        err_count++;
        summarize();
    end

    initial begin
        dmac_req_t   q;
        logic [15:0] v;
        // mapped reg, blocks 2, 0, 1, 3, external
        logic [15:0] dtab [6] = '{16'h0005, 16'h0070, 16'h0250, 16'h0350,
                                  16'h0500, 16'h9000};
        void'($urandom(91));
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            rr(2'(a), v);
            chk("reset_reg", 32'(v), 32'h0);
        end
        for (int t = 0; t < 24; t++) begin
            ctrl = dmac_ctrl_t'(5'($urandom));
            if (t < 4) begin
                ctrl.product_shift_mode = 2'(t);
            end
            rw(DMAC_REG_CTRL, 16'(ctrl));
            q.op = dmac_op_t'(2'(t % 3));
            q.direct = 1'($urandom);
            q.ptr_step = dmac_ptr_t'(2'($urandom % 3));
            if (q.op == DMAC_OP_TABLE_MOVE) begin
                q.ptr_step = DMAC_PTR_DEC;
            end
            q.dma = dtab[$urandom % 6];
            q.pma = ctrl.block_zero_config_bit ? {8'hff, 8'($urandom)}
                                               : 16'($urandom);
            q.repeat_count = (t % 5 == 0) ? 8'h0 : 8'($urandom % 12);
            @(posedge core_clk_i);
            run(q);
            chk_state();
        end
        // with the clock enable low neither a write nor a start may land
        ce_i <= 1'b0;
        rw(DMAC_REG_CTRL, ~16'(ctrl));
        start_i <= 1'b1;
        @(posedge core_clk_i);
        start_i <= 1'b0;
        ce_i <= 1'b1;
        #1;
        chk("frozen_busy", 32'(busy_o), 32'h0);
        rr(DMAC_REG_CTRL, v);
        chk("frozen_ctrl", 32'(v), 32'(ctrl));
        rw(DMAC_REG_STATUS, 16'h0003);
        rw(DMAC_REG_ACC_LO, 16'hffff);
        ovf = 1'b0;
        chk_state();
        summarize();
    end
endmodule
`default_nettype wire

//--- rtl/dmac_core.sv
`default_nettype none
module dmac_core
    import dmac_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        start_i,
    input  wire dmac_req_t   req_i,
    output logic             busy_o,
    output logic [15:0]      prog_addr_o,
    output logic             prog_rd_o,
    input  wire logic [15:0] prog_rdata_i,
    output logic [15:0]      data_addr_o,
    output logic             data_rd_o,
    input  wire logic [15:0] data_rdata_i,
    output logic             data_wr_o,
    output logic [15:0]      data_waddr_o,
    output logic [15:0]      data_wdata_o,
    output logic [31:0]      product_o,
    output logic [15:0]      multiplicand_o,
    input  wire logic [1:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [15:0]      reg_rdata_o
);
    typedef enum logic {
        DMAC_ST_IDLE,
        DMAC_ST_RUN
    } dmac_state_t;

    dmac_state_t state_reg;
    dmac_ctrl_t  ctrl_reg;
    dmac_op_t    op_reg;
    dmac_ptr_t   step_reg;
    logic        direct_reg;
    logic [7:0]  count_reg;
    logic [15:0] prefetch_counter_reg;
    logic [15:0] micro_call_stack_reg;
    logic [15:0] dma_reg;
    logic [31:0] product_reg;
    logic [15:0] multiplicand_reg;
    logic [31:0] acc_reg;
    logic        carry_reg;
    logic        overflow_flag_reg;
    logic        wr_reg;
    logic [15:0] waddr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;

    logic        run;
    logic        last;
    logic        is_table;
    logic        move_ok;
    logic [31:0] shifted;
    logic [32:0] sum_next;
    logic [31:0] acc_next;
    logic        ovf_next;
    logic        in_blk;
    logic [31:0] mul_word;

    assign run      = (state_reg == DMAC_ST_RUN);
    assign last     = (count_reg == 8'h00);
    assign is_table = (op_reg != DMAC_OP_LOAD_SUB);

    // sign-extend both words so the whole 32-bit signed product is exact
    assign mul_word = $signed({{16{data_rdata_i[15]}}, data_rdata_i})
                      * $signed({{16{prog_rdata_i[15]}}, prog_rdata_i});

    // block membership of the data operand; block zero counts only as data
    always_comb begin
        in_blk = 1'b0;
        if (dma_reg >= DMAC_BLK2_LO && dma_reg <= DMAC_BLK2_HI) begin
            in_blk = 1'b1; // RL11
        end
        if (dma_reg >= DMAC_BLK1_LO && dma_reg <= DMAC_BLK1_HI) begin
            in_blk = 1'b1; // RL11
        end
        if (dma_reg >= DMAC_BLK0_LO && dma_reg <= DMAC_BLK0_HI
                && !ctrl_reg.block_zero_config_bit) begin
            in_blk = 1'b1; // RL11
        end
        if (ctrl_reg.expanded_ram && dma_reg >= DMAC_BLK3_LO
                && dma_reg <= DMAC_BLK3_HI) begin
            in_blk = 1'b1; // RL13
        end
    end

    // mapped registers and external memory fall outside every block
    assign move_ok = run && op_reg == DMAC_OP_TABLE_MOVE && in_blk; // RL12

    always_comb begin
        case (ctrl_reg.product_shift_mode)
            2'h0: shifted = product_reg;
            2'h1: shifted = {product_reg[30:0], 1'b0};
            2'h2: shifted = {product_reg[27:0], 4'h0};
            2'h3: shifted = {{6{product_reg[31]}}, product_reg[31:6]}; // RL14
            default: shifted = product_reg;
        endcase
    end

    // add for table ops, subtract for load-multiplicand-subtract
    always_comb begin
        if (is_table) begin
            sum_next = {1'b0, acc_reg} + {1'b0, shifted}; // RL2
            ovf_next = (acc_reg[31] == shifted[31])
                       && (sum_next[31] != acc_reg[31]);
        end else begin
            sum_next = {1'b0, acc_reg} - {1'b0, shifted}; // RL17
            ovf_next = (acc_reg[31] != shifted[31])
                       && (sum_next[31] != acc_reg[31]);
        end
        acc_next = sum_next[31:0];
        if (ovf_next && ctrl_reg.overflow_saturate_mode) begin
            acc_next = acc_reg[31] ? DMAC_SAT_NEG : DMAC_SAT_POS; // RL3
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg  <= DMAC_ST_IDLE;
            op_reg     <= DMAC_OP_TABLE;
            step_reg   <= DMAC_PTR_KEEP;
            direct_reg <= 1'b0;
            count_reg  <= 8'h00;
        end else if (ce_i) begin
            if (!run && start_i) begin
                state_reg  <= DMAC_ST_RUN;
                op_reg     <= req_i.op;
                step_reg   <= req_i.ptr_step;
                direct_reg <= req_i.direct;
                count_reg  <= (req_i.op == DMAC_OP_LOAD_SUB)
                              ? 8'h00 : req_i.repeat_count;
            end else if (run) begin
                if (last) begin
                    state_reg <= DMAC_ST_IDLE;
                end else begin
                    count_reg <= count_reg - 8'h01; // RL10
                end
            end
        end
    end

    // prefetch counter walk and the one-deep micro call stack
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prefetch_counter_reg <= 16'h0000;
            micro_call_stack_reg <= 16'h0000;
        end else if (ce_i) begin
            if (!run && start_i && req_i.op != DMAC_OP_LOAD_SUB) begin
                micro_call_stack_reg <= prefetch_counter_reg; // RL16
                prefetch_counter_reg <= req_i.pma; // RL16
            end else if (run && is_table) begin
                if (last) begin
                    prefetch_counter_reg <= micro_call_stack_reg; // RL16
                end else begin
                    prefetch_counter_reg <=
                        prefetch_counter_reg + 16'h0001; // RL9
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dma_reg <= 16'h0000;
        end else if (ce_i) begin
            if (!run && start_i) begin
                dma_reg <= req_i.dma; // RL4
            end else if (run && !direct_reg) begin
                case (step_reg)
                    DMAC_PTR_INC: dma_reg <= dma_reg + 16'h0001;
                    DMAC_PTR_DEC: dma_reg <= dma_reg - 16'h0001;
                    default:      dma_reg <= dma_reg;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            product_reg       <= 32'h00000000;
            multiplicand_reg  <= 16'h0000;
            acc_reg           <= 32'h00000000;
            carry_reg         <= 1'b0;
        end else if (ce_i && run) begin
            multiplicand_reg <= data_rdata_i; // RL17
            acc_reg          <= acc_next; // RL2
            carry_reg        <= sum_next[32] ^ !is_table; // RL3
            if (is_table) begin
                product_reg <= mul_word; // RL1
            end
        end
    end

    // move write lands one cycle after the read of the same word
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_reg    <= 1'b0;
            waddr_reg <= 16'h0000;
            wdata_reg <= 16'h0000;
        end else if (ce_i) begin
            wr_reg <= move_ok; // RL11
            if (move_ok) begin
                waddr_reg <= dma_reg + 16'h0001; // RL15
                wdata_reg <= data_rdata_i; // RL15
            end
        end
    end

    // overflow flag is sticky; a new overflow beats a software clear
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_reg          <= DMAC_CTRL_RST;
            overflow_flag_reg <= 1'b0;
        end else if (ce_i) begin
            if (reg_wr_i && reg_addr_i == DMAC_REG_CTRL) begin
                ctrl_reg.product_shift_mode <=
                    reg_wdata_i[DMAC_CTRL_SHIFT_LSB +: 2];
                ctrl_reg.overflow_saturate_mode <=
                    reg_wdata_i[DMAC_CTRL_SAT_BIT];
                ctrl_reg.block_zero_config_bit <=
                    reg_wdata_i[DMAC_CTRL_BZ_BIT];
                ctrl_reg.expanded_ram <= reg_wdata_i[DMAC_CTRL_EXP_BIT];
            end
            if (run && ovf_next) begin
                overflow_flag_reg <= 1'b1; // RL3
            end else if (reg_wr_i && reg_addr_i == DMAC_REG_STATUS
                         && reg_wdata_i[DMAC_STAT_OVF_BIT]) begin
                overflow_flag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= 16'h0000;
        end else if (ce_i) begin
            rdata_reg <= 16'h0000;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    DMAC_REG_CTRL:   rdata_reg <= {11'h000, ctrl_reg};
                    DMAC_REG_STATUS: rdata_reg <= {13'h0000, run,
                                         overflow_flag_reg, carry_reg};
                    DMAC_REG_ACC_LO: rdata_reg <= acc_reg[15:0];
                    DMAC_REG_ACC_HI: rdata_reg <= acc_reg[31:16];
                    default:         rdata_reg <= 16'h0000;
                endcase
            end
        end
    end

    assign busy_o         = run;
    assign prog_addr_o    = prefetch_counter_reg;
    assign prog_rd_o      = run && is_table;
    assign data_addr_o    = dma_reg;
    assign data_rd_o      = run;
    assign data_wr_o      = wr_reg;
    assign data_waddr_o   = waddr_reg;
    assign data_wdata_o   = wdata_reg;
    assign product_o      = product_reg;
    assign multiplicand_o = multiplicand_reg;
    assign reg_rdata_o    = rdata_reg;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    direct_dma_fixed_a: assert property ( // RL8
        ce_i && run && direct_reg && !last |=> ce_i |-> $stable(dma_reg))
        else $error("direct data address moved during repeat");
    prog_step_a: assert property ( // RL9
        ce_i && run && is_table && !last
        |=> prefetch_counter_reg == $past(prefetch_counter_reg) + 16'h0001)
        else $error("prefetch counter did not step by one");
    prog_restore_a: assert property ( // RL16
        ce_i && run && is_table && last
        |=> prefetch_counter_reg == $past(micro_call_stack_reg))
        else $error("prefetch counter not restored");
    one_cycle_iter_a: assert property ( // RL10
        ce_i && run && !last |=> run && count_reg == $past(count_reg) - 8'h01)
        else $error("iteration did not finish in one cycle");
    product_load_a: assert property ( // RL1
        ce_i && run && is_table |=> $signed(product_reg) ==
            $past($signed(data_rdata_i)) * $past($signed(prog_rdata_i)))
        else $error("product register wrong");
    shift_six_a: assert property ( // RL14
        ctrl_reg.product_shift_mode == 2'h3
        |-> $signed(shifted) == ($signed(product_reg) >>> 6))
        else $error("shift mode three not right by six");
    move_addr_a: assert property ( // RL15
        ce_i && move_ok
        |=> data_wr_o && data_waddr_o == $past(dma_reg) + 16'h0001)
        else $error("move went to the wrong address");
    no_move_a: assert property ( // RL12
        ce_i && run && (op_reg != DMAC_OP_TABLE_MOVE || !in_blk)
        |=> !data_wr_o)
        else $error("move outside the allowed blocks");
    sat_clamp_a: assert property ( // RL3
        ce_i && run && ovf_next && ctrl_reg.overflow_saturate_mode
        |=> overflow_flag_reg && (acc_reg == DMAC_SAT_POS
                                  || acc_reg == DMAC_SAT_NEG))
        else $error("saturation or overflow flag missing");
endmodule
`default_nettype wire

//--- rtl/dmac_pkg.sv
// Behaviour
// RL1 - data word times program word goes into the product register
// RL2 - same cycle adds mode-shifted previous product to the accumulator
// RL3 - accumulation sets carry and overflow; obeys saturate and shift modes
// RL4 - operands may be anywhere on-chip or off-chip, no address filtering
// RL5 - software sets block zero config bit before tables in block zero
// RL6 - software puts 0ffh in upper program address byte for block zero
// RL7 - software clears upper six data address bits to reach below 1024
// RL8 - direct mode keeps the data address fixed across repetitions
// RL9 - each repetition steps the prefetch counter by one
// RL10 - once running, every iteration takes exactly one cycle
// RL11 - move variant acts as plain multiply plus a move in blocks 0-2
// RL12 - move variant skips the move for mapped registers or external memory
// RL13 - expanded ram variant also allows the move inside block three
// RL14 - product shift mode 3 shifts product right by six bits
// RL15 - the move copies the data word to the next higher data address
// RL16 - save prefetch counter at start, restore it on the last repetition
// RL17 - multiplicand load and subtract of the mode-shifted previous product
`default_nettype none
package dmac_pkg;
    typedef enum logic [1:0] {
        DMAC_OP_TABLE      = 2'h0,
        DMAC_OP_TABLE_MOVE = 2'h1,
        DMAC_OP_LOAD_SUB   = 2'h2
    } dmac_op_t;

    typedef enum logic [1:0] {
        DMAC_PTR_KEEP = 2'h0,
        DMAC_PTR_INC  = 2'h1,
        DMAC_PTR_DEC  = 2'h2
    } dmac_ptr_t;

    typedef struct packed {
        dmac_op_t    op;
        logic        direct;
        dmac_ptr_t   ptr_step;
        logic [15:0] pma;
        logic [15:0] dma;
        logic [7:0]  repeat_count;
    } dmac_req_t;

    typedef struct packed {
        logic       expanded_ram;
        logic       block_zero_config_bit;
        logic       overflow_saturate_mode;
        logic [1:0] product_shift_mode;
    } dmac_ctrl_t;

    localparam logic [1:0] DMAC_REG_CTRL   = 2'h0;
    localparam logic [1:0] DMAC_REG_STATUS = 2'h1;
    localparam logic [1:0] DMAC_REG_ACC_LO = 2'h2;
    localparam logic [1:0] DMAC_REG_ACC_HI = 2'h3;

    localparam int DMAC_CTRL_SHIFT_LSB = 0;
    localparam int DMAC_CTRL_SAT_BIT   = 2;
    localparam int DMAC_CTRL_BZ_BIT    = 3;
    localparam int DMAC_CTRL_EXP_BIT   = 4;
    localparam int DMAC_STAT_C_BIT     = 0;
    localparam int DMAC_STAT_OVF_BIT   = 1;
    localparam int DMAC_STAT_BUSY_BIT = 2;

    localparam dmac_ctrl_t DMAC_CTRL_RST = '0;

    localparam logic [15:0] DMAC_BLK2_LO = 16'h0060;
    localparam logic [15:0] DMAC_BLK2_HI = 16'h007f;
    localparam logic [15:0] DMAC_BLK0_LO = 16'h0200;
    localparam logic [15:0] DMAC_BLK0_HI = 16'h02ff;
    localparam logic [15:0] DMAC_BLK1_LO = 16'h0300;
    localparam logic [15:0] DMAC_BLK1_HI = 16'h03ff;
    localparam logic [15:0] DMAC_BLK3_LO = 16'h0400;
    localparam logic [15:0] DMAC_BLK3_HI = 16'h07ff;

    localparam logic [31:0] DMAC_SAT_POS = 32'h7fffffff;
    localparam logic [31:0] DMAC_SAT_NEG = 32'h80000000;
endpackage
`default_nettype wire
